// >>> design/asc_pkg.sv
`default_nettype none
package asc_pkg;
    // ***************************************
    // register map
    // ***************************************
    localparam logic [3:0] ADDR_CONTROL   = 4'h0;
    localparam logic [3:0] ADDR_CONFIG    = 4'h1;
    localparam logic [3:0] ADDR_STATUS    = 4'h2;
    localparam logic [3:0] ADDR_STCLR     = 4'h3;
    localparam logic [3:0] ADDR_SEQ       = 4'h4;
    localparam logic [3:0] ADDR_TIMING    = 4'h5;
    localparam logic [3:0] ADDR_RESULT    = 4'h6;
    localparam logic [3:0] ADDR_IRQEN     = 4'h7;
    localparam logic [3:0] ADDR_IRQDIS    = 4'h8;
    localparam logic [3:0] ADDR_IRQMASK   = 4'h9;
    // control bits
    localparam int CTL_EN      = 0;
    localparam int CTL_PWRLEAVE = 1;
    localparam int CTL_TRIG    = 2;
    localparam int CTL_BGREQ   = 3;
    localparam int CTL_REFBUF  = 4;
    localparam int CTL_OFF     = 5;
    localparam int CTL_PWRRED  = 6;
    // status bits
    localparam int ST_DONE     = 0;
    localparam int ST_OVR      = 1;
    localparam int ST_WIN      = 2;
    localparam int ST_EN       = 3;
    localparam int ST_BUSY     = 4;
    localparam int ST_PWRRED   = 5;
    localparam int ST_CELLON   = 6;
    // trigger sources, conversion lengths, reset values and sign masks
    localparam logic [2:0] TRG_SW    = 3'h0;
    localparam logic [2:0] TRG_EVENT = 3'h1;
    localparam logic [2:0] TRG_CONT  = 3'h2;
    localparam logic [2:0] TRG_RISE  = 3'h3;
    localparam logic [2:0] TRG_FALL  = 3'h4;
    localparam logic [2:0] TRG_ANY   = 3'h5;
    localparam logic [3:0] CONV_12   = 4'h6;
    localparam logic [3:0] CONV_8    = 4'h4;
    localparam logic [7:0] DIV_RESET = 8'h03;
    localparam logic [7:0] STUP_RESET = 8'h0C;
    localparam logic [11:0] SIGN_FLIP12 = 12'h800;
    localparam logic [11:0] SIGN_FLIP8  = 12'h080;

    typedef struct packed {
        logic [11:0] spare;
        logic [11:0] winHigh;  // window upper bound (unsigned conversion units, before the sign flip)
        logic [3:0]  channel;
        logic        winEnable;
        logic [2:0]  trigSel;
    } asc_seq_lo_s;

    typedef struct packed {
        logic        resolution8;   // 0: 12-bit (reset), 1: 8-bit
        logic        bipolar;       // 1: differential, signed result
        logic [3:0]  sampleTime;
        logic [11:0] winLow;
    } asc_seq_hi_s;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_START  = 3'b001,
        ST_SAMPLE = 3'b011,
        ST_CONV   = 3'b010,
        ST_DONE_S = 3'b110
    } asc_state_e;
endpackage
`default_nettype wire

// >>> design/asc_control.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module asc_control
    import asc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        genericClock,
    input  wire logic        clocksStopped,
    output logic             clockRequest,
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic [31:0]      regRdata,
    input  wire logic        dmaSeqValid,
    input  wire logic [31:0] dmaSeqData,
    input  wire logic        dmaResultRead,
    input  wire logic        eventTrigger,
    input  wire logic        externalTriggerPin,
    output logic [3:0]       cellChannel,
    output logic             cellOn,
    output logic             cellSample,
    output logic             cellConvert,
    input  wire logic [11:0] cellData,
    output logic             eocEventOut,
    output logic             windowEventOut,
    output logic             bandgapRequest,
    output logic             refBufferOn,
    output logic             irqOut
);
    // ***************************************
    // registers
    // ***************************************
    logic        enable_q, enable_d;
    logic        pwrRed_q, pwrRed_d;
    logic        bg_q, bg_d, rb_q, rb_d;
    logic        clock_source_select_q, clock_source_select_d;
    logic [7:0]  divider_q, divider_d;
    logic [31:0] seqLo_q, seqLo_d;
    logic [31:0] seqHi_q, seqHi_d;
    logic [7:0]  startup_q, startup_d;
    logic [15:0] result_q, result_d;
    logic        done_q, done_d, ovr_q, ovr_d, win_q, win_d;
    logic [2:0]  irqEn_q, irqEn_d;
    logic        trigPend_q, trigPend_d;
    logic        extPrev_q;
    logic        genPrev_q;   // generic clock level one cycle back
    logic [7:0]  divCnt_q, divCnt_d;
    logic        cellOn_q, cellOn_d;
    asc_state_e  state_q, state_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [31:0] rdata_q, rdata_d;
    logic        eoc_q, eoc_d, wev_q, wev_d;

    asc_seq_lo_s lo;
    asc_seq_hi_s hi;
    assign lo = asc_seq_lo_s'(seqLo_q);
    assign hi = asc_seq_hi_s'(seqHi_q[$bits(asc_seq_hi_s)-1:0]);

    function automatic logic wr(input logic [3:0] a);
        wr = regWrite && (regAddr == a);
    endfunction

    // conversion clock tick: selected clock divided
    logic srcEdge, adcTick, genEdge, extRise, extFall, autoTrig, run;
    assign genEdge  = genericClock && !genPrev_q;
    assign srcEdge  = clock_source_select_q ? genEdge : 1'b1;
    assign adcTick  = srcEdge && (divCnt_q == 8'h00);
    assign extRise  = externalTriggerPin && !extPrev_q;
    assign extFall  = !externalTriggerPin && extPrev_q;
    // stopped clocks freeze all registers but the event latch, the edge detectors and the one-cycle outputs; events wake the clock
    assign run = !clocksStopped;
    assign clockRequest = clocksStopped && (eventTrigger || trigPend_q);

    always_comb begin
        case (lo.trigSel)
            TRG_EVENT: autoTrig = eventTrigger;
            TRG_CONT:  autoTrig = 1'b1;
            TRG_RISE:  autoTrig = extRise;
            TRG_FALL:  autoTrig = extFall;
            TRG_ANY:   autoTrig = extRise || extFall;
            default:   autoTrig = 1'b0;
        endcase
    end

    logic [11:0] conv;
    logic [11:0] flipped;
    logic [15:0] signedRes;
    logic        busy;
    assign busy = (state_q != ST_IDLE);
    // differential results reported as two's complement
    assign conv = hi.resolution8 ? {4'h0, cellData[11:4]} : cellData;
    // offset binary to two's complement: flip the top bit of the active width
    assign flipped = conv ^ (hi.resolution8 ? SIGN_FLIP8 : SIGN_FLIP12);
    // in differential 8-bit mode the sign fills every bit above bit 7
    assign signedRes = !hi.bipolar ? {4'h0, conv}
        : hi.resolution8 ? {{8{flipped[7]}}, flipped[7:0]}
        : {{4{flipped[11]}}, flipped};

    // ***************************************
    // next state
    // ***************************************
    always_comb begin
        logic ctlOk;
        ctlOk = enable_q;
        enable_d = enable_q; pwrRed_d = pwrRed_q; bg_d = bg_q; rb_d = rb_q;
        clock_source_select_d = clock_source_select_q; divider_d = divider_q; seqLo_d = seqLo_q;
        seqHi_d = seqHi_q; startup_d = startup_q; result_d = result_q;
        done_d = done_q; ovr_d = ovr_q; win_d = win_q; irqEn_d = irqEn_q;
        trigPend_d = trigPend_q; divCnt_d = divCnt_q; cellOn_d = cellOn_q;
        state_d = state_q; cnt_d = cnt_q; rdata_d = 32'h0;
        eoc_d = 1'b0; wev_d = 1'b0;
        if (run) begin
            if (srcEdge) divCnt_d = (divCnt_q == 8'h00) ? divider_q : divCnt_q - 8'h01;
            // control: enable and off always accepted, others only once enabled
            if (wr(ADDR_CONTROL)) begin
                if (regWdata[CTL_EN]) enable_d = 1'b1;
                if (regWdata[CTL_OFF]) enable_d = 1'b0;
                if (ctlOk) begin
                    // entering and leaving power reduction are separate bits
                    if (regWdata[CTL_PWRRED]) pwrRed_d = 1'b1;
                    if (regWdata[CTL_PWRLEAVE]) pwrRed_d = 1'b0;
                    bg_d = regWdata[CTL_BGREQ];
                    rb_d = regWdata[CTL_REFBUF];
                end
            end
            if (wr(ADDR_CONFIG)) begin
                clock_source_select_d = regWdata[8];
                divider_d = regWdata[7:0];
            end
            if (wr(ADDR_SEQ)) seqLo_d = regWdata;
            else if (dmaSeqValid) seqLo_d = dmaSeqData;
            // the timing word also carries the per-conversion mode fields
            if (wr(ADDR_TIMING)) begin
                startup_d = regWdata[7:0];
                seqHi_d = {seqHi_q[31:18], regWdata[25:8]};
            end
            if (wr(ADDR_IRQEN)) irqEn_d = irqEn_q | regWdata[2:0];
            if (wr(ADDR_IRQDIS)) irqEn_d = irqEn_q & ~regWdata[2:0];
            if (wr(ADDR_STCLR)) begin
                if (regWdata[ST_DONE]) done_d = 1'b0;
                if (regWdata[ST_OVR]) ovr_d = 1'b0;
                if (regWdata[ST_WIN]) win_d = 1'b0;
            end
            if (dmaResultRead) done_d = 1'b0;
            if (enable_q && ((wr(ADDR_CONTROL) && regWdata[CTL_TRIG]) || autoTrig))
                trigPend_d = 1'b1;
            case (state_q)
                ST_IDLE: begin
                    if (trigPend_q && enable_q) begin
                        trigPend_d = 1'b0;
                        cnt_d = cellOn_q ? 8'h00 : startup_q;
                        cellOn_d = 1'b1;
                        state_d = ST_START;
                    end else if (pwrRed_q) cellOn_d = 1'b0;
                    else if (enable_q) cellOn_d = 1'b1;
                end
                ST_START: if (adcTick) begin
                    if (cnt_q == 8'h00) begin
                        cnt_d = {4'h0, hi.sampleTime};
                        state_d = ST_SAMPLE;
                    end else cnt_d = cnt_q - 8'h01;
                end
                // sampling is paced by generic clock edges, not the divided tick
                ST_SAMPLE: if (genEdge) begin
                    if (cnt_q == 8'h00) begin
                        cnt_d = {4'h0, hi.resolution8 ? CONV_8 : CONV_12} - 8'h01;
                        state_d = ST_CONV;
                    end else cnt_d = cnt_q - 8'h01;
                end
                ST_CONV: if (adcTick) begin
                    if (cnt_q == 8'h00) state_d = ST_DONE_S;
                    else cnt_d = cnt_q - 8'h01;
                end
                ST_DONE_S: begin
                    result_d = signedRes;
                    // a result read in this very cycle still returns the old value
                    if (done_q && !(wr(ADDR_STCLR) && regWdata[ST_DONE]) && !dmaResultRead
                        && !(regRead && regAddr == ADDR_RESULT))
                        ovr_d = 1'b1;
                    done_d = 1'b1;
                    eoc_d = 1'b1;
                    if (lo.winEnable && conv >= hi.winLow && conv <= lo.winHigh) begin
                        win_d = 1'b1;
                        wev_d = 1'b1;
                    end
                    state_d = ST_IDLE;
                end
                default: state_d = ST_IDLE;
            endcase
            if (regRead) begin
                case (regAddr)
                    ADDR_CONTROL: rdata_d = {25'h0, pwrRed_q, 1'b0, rb_q, bg_q, 3'h0};
                    ADDR_CONFIG:  rdata_d = {23'h0, clock_source_select_q, divider_q};
                    ADDR_STATUS:  rdata_d = {25'h0, cellOn_q, pwrRed_q, busy, enable_q,
                                             win_q, ovr_q, done_q};
                    ADDR_SEQ:     rdata_d = seqLo_q;
                    ADDR_TIMING:  rdata_d = {6'h0, seqHi_q[17:0], startup_q};
                    ADDR_RESULT:  rdata_d = {12'h0, lo.channel, result_q};
                    ADDR_IRQMASK: rdata_d = {29'h0, irqEn_q};
                    default:      rdata_d = 32'h0;
                endcase
                if (regAddr == ADDR_RESULT) done_d = 1'b0;
            end
            if (state_q == ST_DONE_S) done_d = 1'b1; // set wins over clear
        end else if (enable_q && lo.trigSel == TRG_EVENT && eventTrigger) begin
            // latch the event: the request must outlast its one-cycle pulse
            trigPend_d = 1'b1;
        end
    end

    // ***************************************
    // registering
    // ***************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enable_q <= 1'b0; pwrRed_q <= 1'b0; bg_q <= 1'b0; rb_q <= 1'b0;
            clock_source_select_q <= 1'b0; divider_q <= DIV_RESET; seqLo_q <= 32'h0;
            seqHi_q <= 32'h0; startup_q <= STUP_RESET; result_q <= 16'h0;
            done_q <= 1'b0; ovr_q <= 1'b0; win_q <= 1'b0; irqEn_q <= 3'h0;
            trigPend_q <= 1'b0; extPrev_q <= 1'b0; genPrev_q <= 1'b0;
            divCnt_q <= 8'h00; cellOn_q <= 1'b0; state_q <= ST_IDLE;
            cnt_q <= 8'h00; rdata_q <= 32'h0; eoc_q <= 1'b0; wev_q <= 1'b0;
        end else begin
            enable_q <= enable_d; pwrRed_q <= pwrRed_d; bg_q <= bg_d; rb_q <= rb_d;
            clock_source_select_q <= clock_source_select_d; divider_q <= divider_d; seqLo_q <= seqLo_d;
            seqHi_q <= seqHi_d; startup_q <= startup_d; result_q <= result_d;
            done_q <= done_d; ovr_q <= ovr_d; win_q <= win_d; irqEn_q <= irqEn_d;
            trigPend_q <= trigPend_d; extPrev_q <= externalTriggerPin;
            genPrev_q <= genericClock; divCnt_q <= divCnt_d; cellOn_q <= cellOn_d;
            state_q <= state_d; cnt_q <= cnt_d; rdata_q <= rdata_d;
            eoc_q <= eoc_d; wev_q <= wev_d;
        end
    end

    // ***************************************
    // outputs
    // ***************************************
    assign regRdata       = rdata_q;
    assign cellChannel    = lo.channel;
    assign cellOn         = cellOn_q;
    assign cellSample     = (state_q == ST_SAMPLE);
    assign cellConvert    = (state_q == ST_CONV);
    assign eocEventOut    = eoc_q;
    assign windowEventOut = wev_q;
    assign bandgapRequest = bg_q;
    assign refBufferOn    = rb_q;
    assign irqOut = |(irqEn_q & {win_q, ovr_q, done_q});

    // ***************************************
    // checks
    // ***************************************
    property p_ctlIgnored;
        @(posedge mclk) disable iff (!rst_n)
        (!enable_q && regWrite && regAddr == ADDR_CONTROL && !regWdata[CTL_EN]) |=> !enable_q && $stable(pwrRed_q);
    endproperty
    a_ctlIgnored: assert property (p_ctlIgnored) else $error("control taken while off");

    property p_eoc;
        @(posedge mclk) disable iff (!rst_n)
        (state_q == ST_DONE_S && run) |=> eocEventOut && done_q;
    endproperty
    a_eoc: assert property (p_eoc) else $error("no end event");

    property p_ovr;
        @(posedge mclk) disable iff (!rst_n)
        (state_q == ST_DONE_S && run && done_q && !regWrite && !regRead && !dmaResultRead) |=> ovr_q;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun missed");

    property p_halt;
        @(posedge mclk) disable iff (!rst_n)
        clocksStopped |=> $stable(state_q) && $stable(cnt_q);
    endproperty
    a_halt: assert property (p_halt) else $error("moved while halted");

    // an event seen while halted keeps the clock request up
    property p_wake;
        @(posedge mclk) disable iff (!rst_n)
        (clocksStopped && enable_q && lo.trigSel == TRG_EVENT && eventTrigger)
            |=> (clockRequest || !clocksStopped);
    endproperty
    a_wake: assert property (p_wake) else $error("no clock request on event");

    // the window event only ever rides on an end-of-conversion
    property p_winEvt;
        @(posedge mclk) disable iff (!rst_n)
        windowEventOut |-> eocEventOut;
    endproperty
    a_winEvt: assert property (p_winEvt) else $error("window event alone");

    // idle under power reduction drops the cell
    property p_pwrOff;
        @(posedge mclk) disable iff (!rst_n)
        (state_q == ST_IDLE && pwrRed_q && !trigPend_q && run) |=> !cellOn;
    endproperty
    a_pwrOff: assert property (p_pwrOff) else $error("cell left on while idle");

    // a cold cell starts with the full programmed startup count
    property p_startup;
        @(posedge mclk) disable iff (!rst_n)
        (state_q == ST_IDLE && trigPend_q && enable_q && run && !cellOn_q)
            |=> state_q == ST_START && cnt_q == $past(startup_q);
    endproperty
    a_startup: assert property (p_startup) else $error("startup count skipped");
endmodule
`default_nettype wire

// >>> test/asc_cell_model.sv
`timescale 1ns/1ps
`default_nettype none
module asc_cell_model
    import asc_pkg::*;
#(
    parameter int MIN_GAP = 64
)
(
    input  wire logic        mclk,
    input  wire logic [3:0]  cellChannel,
    input  wire logic        cellConvert,
    input  wire logic        fireReq,
    output logic [11:0]      cellData,
    output var logic         eventTrigger
);
    // ****************************************
    // converter cell and event source
    // ****************************************
    logic [1:0]  hold_q = 2'h0;
    logic [11:0] noise_q = 12'h000;
    int          gap_q = MIN_GAP;

    // data held two cycles past conversion, scrambled after so stale values never pass
    always @(posedge mclk) begin
        hold_q <= cellConvert ? 2'h2 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
        noise_q <= ~noise_q + 12'h035;
    end
    assign cellData = (cellConvert || hold_q != 2'h0) ?
        {cellChannel, ~cellChannel, 4'h9} : noise_q;

    // refuses to fire closer than one conversion plus startup
    always @(posedge mclk) begin
        eventTrigger <= 1'b0;
        gap_q <= gap_q + 1;
        if (fireReq && gap_q >= MIN_GAP) begin
            eventTrigger <= 1'b1;
            gap_q <= 0;
        end
    end
endmodule
`default_nettype wire

// >>> test/tb_asc_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_asc_control;
    import asc_pkg::*;
    // ****************************************
    // bench signals and instances
    // ****************************************
    logic        mclk = 1'b0, rst_n = 1'b0, genericClock = 1'b0, clocksStopped = 1'b0;
    logic        regWrite = 1'b0, regRead = 1'b0, fireReq = 1'b0, rdPend = 1'b0;
    logic        dmaSeqValid = 1'b0, dmaResultRead = 1'b0, externalTriggerPin = 1'b0;
    logic [3:0]  regAddr = 4'h0, cellChannel, ch;
    logic [31:0] regWdata = 32'h0, dmaSeqData = 32'h0, regRdata;
    logic [11:0] cellData;
    logic        clockRequest, cellOn, cellSample, cellConvert, eocEventOut, windowEventOut;
    logic        bandgapRequest, refBufferOn, irqOut, eventTrigger, smpPrev = 1'b0;
    logic [63:0] expQ[$];
    int          n_mismatch = 0, comparisons = 0, nEoc = 0, nWin = 0, n;
    int          seed = 32'h9082, cvCnt = 0, cvLast = 0, upCnt = 0, upAtSmp = 0;

    asc_control asc_control_i (.mclk, .rst_n, .genericClock, .clocksStopped, .clockRequest,
        .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .dmaSeqValid, .dmaSeqData,
        .dmaResultRead, .eventTrigger, .externalTriggerPin, .cellChannel, .cellOn,
        .cellSample, .cellConvert, .cellData, .eocEventOut, .windowEventOut,
        .bandgapRequest, .refBufferOn, .irqOut);
    asc_cell_model asc_cell_model_i (.mclk, .cellChannel, .cellConvert, .fireReq,
        .cellData, .eventTrigger);

    always #2.5 mclk = ~mclk;
    // generic clock at half the bus rate
    always @(posedge mclk) genericClock <= ~genericClock;

    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        repeat (4) @(posedge mclk);
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    // expected value and mask noted before the strobe goes out
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back({e, m});
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
    endtask
    task automatic waitEoc();
        int k;
        for (k = 0; k < 3000 && eocEventOut !== 1'b1; k++) @(posedge mclk);
        check(k < 3000, 1'b1);
        repeat (2) @(posedge mclk);
    endtask

    // read data stands only the cycle after the strobe; also tally events and cell timing
    always @(posedge mclk) begin
        if (rdPend && expQ.size() > 0) begin
            check(regRdata & expQ[0][31:0], expQ[0][63:32]);
            void'(expQ.pop_front());
        end
        rdPend = regRead;
        nEoc += eocEventOut;
        nWin += windowEventOut;
        if (cellConvert) cvCnt++;
        else if (cvCnt != 0) begin
            cvLast = cvCnt;
            cvCnt = 0;
        end
        if (!cellOn) upCnt = 0;
        else upCnt++;
        if (cellSample && !smpPrev) upAtSmp = upCnt;
        smpPrev = cellSample;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rd(ADDR_STATUS, 32'h0, 32'h7F);
        rd(ADDR_TIMING, 32'h0C, 32'h020000FF);
        rd(ADDR_CONFIG, 32'h003, 32'h1FF);
        wr(ADDR_CONTROL, 32'h1C);
        repeat (200) @(posedge mclk);
        check({nEoc[7:0], bandgapRequest, refBufferOn}, 10'h0);
        wr(ADDR_CONTROL, 32'h19);
        rd(ADDR_STATUS, 32'h08, 32'h08);
        wr(ADDR_TIMING, 32'h0C);
        // random channels, window spans the full range
        for (int i = 0; i < 3; i++) begin
            ch = 4'($random(seed));
            wr(ADDR_SEQ, {12'h0, 12'hFFF, ch, 1'b1, TRG_SW});
            wr(ADDR_CONTROL, 32'h1D);
            waitEoc();
            rd(ADDR_RESULT, {12'h0, ch, 4'h0, ch, ~ch, 4'h9}, 32'h000FFFFF);
        end
        check(upAtSmp >= 45, 1'b1);
        check(cvLast >= 21 && cvLast <= 27, 1'b1);
        check({nEoc[7:0], nWin[7:0], bandgapRequest, refBufferOn}, 18'h00C0F);
        // two results without a read in between
        wr(ADDR_CONTROL, 32'h1D);
        waitEoc();
        wr(ADDR_CONTROL, 32'h1D);
        waitEoc();
        rd(ADDR_STATUS, 32'h2, 32'h2);
        rd(ADDR_RESULT, 32'h0, 32'h0);
        rd(ADDR_STATUS, 32'h2, 32'h2);
        wr(ADDR_STCLR, 32'h3);
        rd(ADDR_STATUS, 32'h0, 32'h3);
        wr(ADDR_IRQEN, 32'h1);
        wr(ADDR_CONTROL, 32'h1D);
        waitEoc();
        check(irqOut, 1'b1);
        wr(ADDR_STCLR, 32'h1);
        repeat (2) @(posedge mclk);
        check(irqOut, 1'b0);
        wr(ADDR_IRQDIS, 32'h1);
        // settings by the receive channel, result taken by the transmit channel
        ch = 4'($random(seed));
        @(posedge mclk);
        dmaSeqData <= {12'h0, 12'hFFF, ch, 1'b0, TRG_SW};
        dmaSeqValid <= 1'b1;
        @(posedge mclk);
        dmaSeqValid <= 1'b0;
        wr(ADDR_CONTROL, 32'h1D);
        waitEoc();
        dmaResultRead <= 1'b1;
        @(posedge mclk);
        dmaResultRead <= 1'b0;
        rd(ADDR_STATUS, 32'h0, 32'h1);
        rd(ADDR_RESULT, {12'h0, ch, 4'h0, ch, ~ch, 4'h9}, 32'h000FFFFF);
        wr(ADDR_TIMING, 32'h0200000C);
        wr(ADDR_CONTROL, 32'h1D);
        waitEoc();
        check(cvLast >= 13 && cvLast <= 19, 1'b1);
        // generic clock undivided, differential 8-bit: sign fills the upper byte
        wr(ADDR_CONFIG, 32'h100);
        wr(ADDR_TIMING, 32'h0300000C);
        wr(ADDR_CONTROL, 32'h1D);
        waitEoc();
        check(cvLast >= 7 && cvLast <= 9, 1'b1);
        rd(ADDR_RESULT, {12'h0, ch, {8{~ch[3]}}, ~ch[3], ch[2:0], ~ch}, 32'hFFFFF);
        wr(ADDR_CONFIG, 32'h003);
        // event arrives while clocks are stopped
        wr(ADDR_TIMING, 32'h0C);
        wr(ADDR_SEQ, {12'h0, 12'hFFF, ch, 1'b0, TRG_EVENT});
        clocksStopped <= 1'b1;
        fireReq <= 1'b1;
        @(posedge mclk);
        fireReq <= 1'b0;
        n = nEoc;
        repeat (100) @(posedge mclk);
        check({clockRequest, nEoc[7:0]}, {1'b1, n[7:0]});
        clocksStopped <= 1'b0;
        waitEoc();
        wr(ADDR_SEQ, {12'h0, 12'hFFF, ch, 1'b0, TRG_RISE});
        externalTriggerPin <= 1'b1;
        waitEoc();
        // falling edge under the either-edge source
        wr(ADDR_SEQ, {12'h0, 12'hFFF, ch, 1'b0, TRG_ANY});
        externalTriggerPin <= 1'b0;
        waitEoc();
        // idle first, then power reduction
        wr(ADDR_SEQ, {12'h0, 12'hFFF, ch, 1'b0, TRG_SW});
        rd(ADDR_STATUS, 32'h0, 32'h10);
        wr(ADDR_CONTROL, 32'h59);
        repeat (20) @(posedge mclk);
        check(cellOn, 1'b0);
        wr(ADDR_CONTROL, 32'h5D);
        waitEoc();
        check(upAtSmp >= 45, 1'b1);
        report_and_stop();
    end

    // hang guard, far beyond the expected run length
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
